// ### verilog/dmm_data_memory.sv
// Data memory register file: special function area, RAM and indirect ports
// Function
// - Memory is 8 bits wide from zero
// - Special area first, general RAM follows
// - Special registers at fixed decoded addresses
// - Unused special locations read as zero
// - General RAM is readable and writable
// - Single bit set and clear supported
// - Read-only registers ignore writes
// - Ports act on location in their pointer
// - Pointer at port: read zero, no write
// - Pointers are ordinary readable writable registers
// - Accumulator takes ALU results, moves via it
// - Program counter low byte writable, page-local
// - Dummy cycle after program counter write
// - Table high byte read-only, table loaded
// - Flag writes keep timeout and powerdown
module dmm_data_memory
   import dmm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic [7:0] rd_addr,
   output logic      [7:0] rd_data,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_addr,
   input  wire logic [1:0] wr_op,
   input  wire logic [2:0] wr_bit,
   input  wire logic [7:0] wr_data,
   input  wire logic       alu_wr_en,
   input  wire logic [7:0] alu_result,
   output logic      [7:0] alu_result_reg,
   input  wire logic       lookup_load,
   input  wire logic [7:0] lookup_high_in,
   input  wire logic       flags_arith_load,
   input  wire logic [3:0] flags_arith_in,
   input  wire logic       timeout_flag_in,
   input  wire logic       powerdown_flag_in,
   input  wire logic [7:0] pc_low_in,
   output logic      [7:0] program_counter_low,
   output logic            pc_low_written,
   output logic            dummy_cycle
);

   logic [7:0] pointer_zero_r;
   logic [7:0] pointer_one_r;
   logic [7:0] pc_low_r;
   logic [7:0] lookup_ptr_r;
   logic [7:0] lookup_high_r;
   logic [7:0] wdt_setting_r;
   logic [3:0] flags_arith_r;
   logic [7:0] int_ctrl_r;
   logic [7:0] timer_count_r;
   logic [7:0] timer_ctrl_r;
   logic [7:0] pa_data_r;
   logic [7:0] pa_dir_r;
   logic [7:0] pa_pullup_r;
   logic [7:0] pa_wake_r;
   logic [7:0] sys_system_control_zero_r;
   logic [7:0] sys_system_control_one_r;
   logic [7:0] conv_low_r;
   logic [7:0] conv_high_r;
   logic [7:0] conv_ctrl_r;
   logic [7:0] conv_clk_r;
   logic [7:0] gp_mem_r [GP_DEPTH];
   logic       dummy_r;
   logic       pc_wr_r;
   logic [7:0] rd_eff;
   logic [7:0] wr_eff;
   logic       rd_null;
   logic       wr_null;
   logic [7:0] wr_old;
   logic [7:0] wr_nxt;
   logic       wr_go;

   // Resolve a port address through its pointer, the pointer's own value is a full address
   function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                          input logic [7:0] p1);
      if (a == ADDR_PORT_ZERO) begin
         return p0;
      end
      if (a == ADDR_PORT_ONE) begin
         return p1;
      end
      return a;
   endfunction

   // Plain decode of an effective address into its stored byte
   function automatic logic [7:0] fetch(input logic [7:0] a);
      logic [7:0] v;
      v = ZERO_BYTE;
      unique case (a)
         ADDR_POINTER_ZERO: v = pointer_zero_r;
         ADDR_POINTER_ONE:  v = pointer_one_r;
         ADDR_ALU_RESULT:   v = alu_result_reg;
         ADDR_PC_LOW:       v = pc_low_r;
         ADDR_LOOKUP_PTR:   v = lookup_ptr_r;
         ADDR_LOOKUP_HIGH:  v = lookup_high_r;
         ADDR_WDT_SETTING:  v = wdt_setting_r;
         ADDR_FLAGS:        v = {2'b00, timeout_flag_in, powerdown_flag_in, flags_arith_r};
         ADDR_INT_CTRL:     v = int_ctrl_r;
         ADDR_TIMER_COUNT:  v = timer_count_r;
         ADDR_TIMER_CTRL:   v = timer_ctrl_r;
         ADDR_PA_DATA:      v = pa_data_r;
         ADDR_PA_DIR:       v = pa_dir_r;
         ADDR_PA_PULLUP:    v = pa_pullup_r;
         ADDR_PA_WAKE:      v = pa_wake_r;
         ADDR_SYS_SYSTEM_CONTROL_ZERO:    v = sys_system_control_zero_r;
         ADDR_SYS_SYSTEM_CONTROL_ONE:    v = sys_system_control_one_r;
         ADDR_CONV_LOW:     v = conv_low_r;
         ADDR_CONV_HIGH:    v = conv_high_r;
         ADDR_CONV_CTRL:    v = conv_ctrl_r;
         ADDR_CONV_CLK:     v = conv_clk_r;
         default: begin
            if (a >= ADDR_GP_FIRST) begin
               v = gp_mem_r[a - ADDR_GP_FIRST];
            end
         end
      endcase
      return v;
   endfunction

   // Read path: ports resolve through pointers, a port reached indirectly reads zero
   always_comb begin
      rd_eff  = resolve(rd_addr, pointer_zero_r, pointer_one_r);
      rd_null = (rd_eff == ADDR_PORT_ZERO) || (rd_eff == ADDR_PORT_ONE);
      rd_data = rd_null ? ZERO_BYTE : fetch(rd_eff);
   end

   // Write path: whole-byte write or single-bit read-modify-write of the target
   always_comb begin
      wr_eff  = resolve(wr_addr, pointer_zero_r, pointer_one_r);
      wr_null = (wr_eff == ADDR_PORT_ZERO) || (wr_eff == ADDR_PORT_ONE);
      wr_old  = fetch(wr_eff);
      wr_go   = ce && wr_en && !wr_null;
      unique case (wr_op)
         DMM_OP_SET: wr_nxt = wr_old | (8'h01 << wr_bit);
         DMM_OP_CLR: wr_nxt = wr_old & ~(8'h01 << wr_bit);
         default:    wr_nxt = wr_data;
      endcase
   end

   // Pointer registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pointer_zero_r <= ZERO_BYTE;
         pointer_one_r  <= ZERO_BYTE;
      end else if (wr_go) begin
         if (wr_eff == ADDR_POINTER_ZERO) begin
            pointer_zero_r <= wr_nxt;
         end
         if (wr_eff == ADDR_POINTER_ONE) begin
            pointer_one_r <= wr_nxt;
         end
      end
   end

   // Accumulator: ALU result wins over a memory write in the same cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         alu_result_reg <= ZERO_BYTE;
      end else if (ce) begin
         if (alu_wr_en) begin
            alu_result_reg <= alu_result;
         end else if (wr_en && !wr_null && wr_eff == ADDR_ALU_RESULT) begin
            alu_result_reg <= wr_nxt;
         end
      end
   end

   // Program counter low byte: core's value is tracked, a write forces a page-local jump
   // The byte is held in the cycle after a write, while the core reloads its counter
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pc_low_r <= ZERO_BYTE;
         pc_wr_r  <= 1'b0;
      end else if (ce) begin
         pc_wr_r <= wr_go && (wr_eff == ADDR_PC_LOW);
         if (wr_go && wr_eff == ADDR_PC_LOW) begin
            pc_low_r <= wr_nxt;
         end else if (!pc_wr_r) begin
            pc_low_r <= pc_low_in; // Core still shows its old byte while pc_wr_r is high
         end
      end
   end

   // One dummy instruction cycle follows each program counter low write
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dummy_r <= 1'b0;
      end else if (ce) begin
         dummy_r <= pc_wr_r;
      end
   end

   assign program_counter_low = pc_low_r;
   assign pc_low_written      = pc_wr_r;
   assign dummy_cycle         = dummy_r;

   // Table high byte: loaded only by table reads, program writes dropped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         lookup_high_r <= ZERO_BYTE;
      end else if (ce && lookup_load) begin
         lookup_high_r <= lookup_high_in;
      end
   end

   // Arithmetic flags: writable low nibble, timeout and powerdown never written
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flags_arith_r <= 4'h0;
      end else if (ce) begin
         if (wr_go && wr_eff == ADDR_FLAGS) begin
            flags_arith_r <= wr_nxt[3:0];
         end else if (flags_arith_load) begin
            flags_arith_r <= flags_arith_in;
         end
      end
   end

   // Ordinary special registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         lookup_ptr_r  <= ZERO_BYTE;
         wdt_setting_r <= ZERO_BYTE;
         int_ctrl_r    <= ZERO_BYTE;
         timer_count_r <= ZERO_BYTE;
         timer_ctrl_r  <= ZERO_BYTE;
         pa_data_r     <= ZERO_BYTE;
         pa_dir_r      <= ZERO_BYTE;
         pa_pullup_r   <= ZERO_BYTE;
         pa_wake_r     <= ZERO_BYTE;
         sys_system_control_zero_r   <= ZERO_BYTE;
         sys_system_control_one_r   <= ZERO_BYTE;
         conv_low_r    <= ZERO_BYTE;
         conv_high_r   <= ZERO_BYTE;
         conv_ctrl_r   <= ZERO_BYTE;
         conv_clk_r    <= ZERO_BYTE;
      end else if (wr_go) begin
         unique case (wr_eff)
            ADDR_LOOKUP_PTR:  lookup_ptr_r  <= wr_nxt;
            ADDR_WDT_SETTING: wdt_setting_r <= wr_nxt;
            ADDR_INT_CTRL:    int_ctrl_r    <= wr_nxt;
            ADDR_TIMER_COUNT: timer_count_r <= wr_nxt;
            ADDR_TIMER_CTRL:  timer_ctrl_r  <= wr_nxt;
            ADDR_PA_DATA:     pa_data_r     <= wr_nxt;
            ADDR_PA_DIR:      pa_dir_r      <= wr_nxt;
            ADDR_PA_PULLUP:   pa_pullup_r   <= wr_nxt;
            ADDR_PA_WAKE:     pa_wake_r     <= wr_nxt;
            ADDR_SYS_SYSTEM_CONTROL_ZERO:   sys_system_control_zero_r   <= wr_nxt;
            ADDR_SYS_SYSTEM_CONTROL_ONE:   sys_system_control_one_r   <= wr_nxt;
            ADDR_CONV_LOW:    conv_low_r    <= wr_nxt;
            ADDR_CONV_HIGH:   conv_high_r   <= wr_nxt;
            ADDR_CONV_CTRL:   conv_ctrl_r   <= wr_nxt;
            ADDR_CONV_CLK:    conv_clk_r    <= wr_nxt;
            default: ;
         endcase
      end
   end

   // General purpose RAM, one generate entry per location
   for (genvar i = 0; i < GP_DEPTH; i++) begin : g_ram
      always_ff @(posedge clk) begin
         if (!resetn) begin
            gp_mem_r[i] <= ZERO_BYTE;
         end else if (wr_go && wr_eff == ADDR_GP_FIRST + 8'(i)) begin
            gp_mem_r[i] <= wr_nxt;
         end
      end
   end

   // Checks
   property p_unused_zero;
      @(posedge clk) disable iff (!resetn)
      (rd_addr == 8'h04 || rd_addr == 8'h0E || rd_addr == 8'h24 || rd_addr == 8'h5F) |-> rd_data == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused location not zero");

   property p_port_indirect;
      @(posedge clk) disable iff (!resetn)
      (rd_addr == ADDR_PORT_ZERO && pointer_zero_r == ADDR_POINTER_ONE) |-> rd_data == pointer_one_r;
   endproperty
   a_port_indirect: assert property (p_port_indirect) else $error("port zero not via pointer");

   property p_port_self;
      @(posedge clk) disable iff (!resetn)
      (rd_addr == ADDR_PORT_ONE && pointer_one_r == ADDR_PORT_ZERO) |-> rd_data == 8'h00;
   endproperty
   a_port_self: assert property (p_port_self) else $error("self indirect read not zero");

   property p_pointer_write;
      @(posedge clk) disable iff (!resetn)
      (ce && wr_en && wr_op == DMM_OP_WRITE && wr_addr == ADDR_POINTER_ZERO) |=> pointer_zero_r == $past(wr_data);
   endproperty
   a_pointer_write: assert property (p_pointer_write) else $error("pointer write lost");

   property p_lookup_ro;
      @(posedge clk) disable iff (!resetn)
      (ce && !lookup_load) |=> $stable(lookup_high_r);
   endproperty
   a_lookup_ro: assert property (p_lookup_ro) else $error("table high byte changed");

   property p_alu_load;
      @(posedge clk) disable iff (!resetn)
      (ce && alu_wr_en) |=> alu_result_reg == $past(alu_result);
   endproperty
   a_alu_load: assert property (p_alu_load) else $error("accumulator missed alu result");

   sequence s_pc_write;
      ce && wr_go && wr_eff == ADDR_PC_LOW;
   endsequence
   sequence s_dummy_after;
      ce ##1 (dummy_cycle && ce);
   endsequence
   property p_pc_dummy;
      @(posedge clk) disable iff (!resetn)
      s_pc_write |=> pc_low_written ##0 s_dummy_after;
   endproperty
   a_pc_dummy: assert property (p_pc_dummy) else $error("no dummy cycle after pc write");

   property p_pc_value;
      @(posedge clk) disable iff (!resetn)
      s_pc_write |=> program_counter_low == $past(wr_nxt);
   endproperty
   a_pc_value: assert property (p_pc_value) else $error("pc low not loaded");

   property p_flags_keep;
      @(posedge clk) disable iff (!resetn)
      (rd_addr == ADDR_FLAGS) |-> rd_data[7:6] == 2'b00 && rd_data[5] == timeout_flag_in
                                  && rd_data[4] == powerdown_flag_in;
   endproperty
   a_flags_keep: assert property (p_flags_keep) else $error("flag high bits wrong");

   property p_bit_set;
      @(posedge clk) disable iff (!resetn)
      (ce && wr_en && wr_op == DMM_OP_SET && wr_addr == ADDR_GP_FIRST) |=> gp_mem_r[0][$past(wr_bit)];
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set failed");

   property p_pc_hold;
      @(posedge clk) disable iff (!resetn)
      (ce && pc_low_written && !(wr_go && wr_eff == ADDR_PC_LOW)) |=> $stable(program_counter_low);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc low lost while core reloads");

   property p_gp_write;
      @(posedge clk) disable iff (!resetn)
      (ce && wr_en && wr_op == DMM_OP_WRITE && wr_addr >= ADDR_GP_FIRST)
         |=> gp_mem_r[$past(wr_addr) - ADDR_GP_FIRST] == $past(wr_data);
   endproperty
   a_gp_write: assert property (p_gp_write) else $error("general ram write lost");

   property p_port_write;
      @(posedge clk) disable iff (!resetn)
      (ce && wr_en && wr_op == DMM_OP_WRITE && wr_addr == ADDR_PORT_ZERO && pointer_zero_r >= ADDR_GP_FIRST)
         |=> gp_mem_r[$past(pointer_zero_r) - ADDR_GP_FIRST] == $past(wr_data);
   endproperty
   a_port_write: assert property (p_port_write) else $error("port write missed pointed location");

   property p_port_clear;
      @(posedge clk) disable iff (!resetn)
      (ce && wr_en && wr_op == DMM_OP_CLR && wr_addr == ADDR_PORT_ZERO && pointer_zero_r >= ADDR_GP_FIRST)
         |=> !gp_mem_r[$past(pointer_zero_r) - ADDR_GP_FIRST][$past(wr_bit)];
   endproperty
   a_port_clear: assert property (p_port_clear) else $error("bit clear through port failed");

   property p_flag_write;
      @(posedge clk) disable iff (!resetn)
      (ce && wr_en && wr_op == DMM_OP_WRITE && wr_addr == ADDR_FLAGS)
         |=> {4'h0, flags_arith_r} == ($past(wr_data) & FLAG_WR_MASK);
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("arithmetic flags not written");

   property p_dummy_once;
      @(posedge clk) disable iff (!resetn)
      (ce && dummy_cycle && !pc_low_written) |=> !dummy_cycle;
   endproperty
   a_dummy_once: assert property (p_dummy_once) else $error("dummy cycle longer than one");
endmodule

// ### verilog/dmm_pkg.sv
// Package with the data memory map, field layouts and reset values
package dmm_pkg;
   localparam logic [7:0] ADDR_PORT_ZERO    = 8'h00;
   localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
   localparam logic [7:0] ADDR_PORT_ONE     = 8'h02;
   localparam logic [7:0] ADDR_POINTER_ONE  = 8'h03;
   localparam logic [7:0] ADDR_ALU_RESULT   = 8'h05;
   localparam logic [7:0] ADDR_PC_LOW       = 8'h06;
   localparam logic [7:0] ADDR_LOOKUP_PTR   = 8'h07;
   localparam logic [7:0] ADDR_LOOKUP_HIGH  = 8'h08;
   localparam logic [7:0] ADDR_WDT_SETTING  = 8'h09;
   localparam logic [7:0] ADDR_FLAGS        = 8'h0A;
   localparam logic [7:0] ADDR_INT_CTRL     = 8'h0B;
   localparam logic [7:0] ADDR_TIMER_COUNT  = 8'h0C;
   localparam logic [7:0] ADDR_TIMER_CTRL   = 8'h0D;
   localparam logic [7:0] ADDR_PA_DATA      = 8'h10;
   localparam logic [7:0] ADDR_PA_DIR       = 8'h11;
   localparam logic [7:0] ADDR_PA_PULLUP    = 8'h12;
   localparam logic [7:0] ADDR_PA_WAKE      = 8'h13;
   localparam logic [7:0] ADDR_SYS_SYSTEM_CONTROL_ZERO    = 8'h1A;
   localparam logic [7:0] ADDR_SYS_SYSTEM_CONTROL_ONE    = 8'h1B;
   localparam logic [7:0] ADDR_CONV_LOW     = 8'h20;
   localparam logic [7:0] ADDR_CONV_HIGH    = 8'h21;
   localparam logic [7:0] ADDR_CONV_CTRL    = 8'h22;
   localparam logic [7:0] ADDR_CONV_CLK     = 8'h23;
   // General purpose RAM follows the special area
   localparam logic [7:0] ADDR_GP_FIRST     = 8'h60;
   localparam logic [7:0] ADDR_GP_LAST      = 8'hFF;
   localparam int         GP_DEPTH          = 160;
   // Flag register layout
   localparam logic [7:0] FLAG_WR_MASK      = 8'h0F;
   localparam logic [7:0] FLAG_RD_MASK      = 8'h3F;
   localparam int         FLAG_TIMEOUT_BIT  = 5;
   localparam int         FLAG_PDOWN_BIT    = 4;
   localparam logic [7:0] ZERO_BYTE         = 8'h00;
   // Operation codes from the core
   typedef enum logic [1:0] {
      DMM_OP_WRITE = 2'b00,
      DMM_OP_SET   = 2'b01,
      DMM_OP_CLR   = 2'b10
   } dmm_op_e;
endpackage

// ### bench/dmm_core_model.sv
// Core model: program counter source that follows page jumps and dummy cycles
module dmm_core_model #(
   parameter bit TIMEOUT_V = 1'b1,
   parameter bit PDOWN_V   = 1'b0
)(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [7:0] program_counter_low,
   input  wire logic       pc_low_written,
   input  wire logic       dummy_cycle,
   output logic      [7:0] pc_low_in,
   output logic            timeout_flag_in,
   output logic            powerdown_flag_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pc_r;
   // Jump to the written low byte, stall over the dummy cycle, else step
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pc_r <= 8'h00;
      end else if (pc_low_written) begin
         pc_r <= program_counter_low;
      end else if (!dummy_cycle) begin
         pc_r <= pc_r + 8'h01;
      end
   end
   // Power management flags stay fixed in this model
   assign pc_low_in         = pc_r;
   assign timeout_flag_in   = TIMEOUT_V;
   assign powerdown_flag_in = PDOWN_V;
endmodule

// ### bench/data_memory_map_indirect_tb.sv
// Self-checking bench for the data memory register file
module data_memory_map_indirect_tb
   import dmm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  rd_addr = 8'h00;
   logic        wr_en = 1'b0;
   logic [7:0]  wr_addr = 8'h00;
   logic [1:0]  wr_op = 2'b00;
   logic [2:0]  wr_bit = 3'h0;
   logic [7:0]  wr_data = 8'h00;
   logic        alu_wr_en = 1'b0;
   logic [7:0]  alu_result = 8'h00;
   logic        lookup_load = 1'b0;
   logic [7:0]  lookup_high_in = 8'h00;
   logic        flags_arith_load = 1'b0;
   logic [3:0]  flags_arith_in = 4'h0;
   wire  [7:0]  rd_data, alu_result_reg, pc_low_in, program_counter_low;
   wire         timeout_flag_in, powerdown_flag_in, pc_low_written, dummy_cycle;
   int          fails = 0;
   int          checked = 0;
   logic [31:0] seed = 32'hFE5CAD7A;
   logic [7:0]  rw_list [18] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h10,
                                 8'h11, 8'h12, 8'h13, 8'h1A, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h23};
   logic [7:0]  unused_list [8] = '{8'h04, 8'h0E, 8'h0F, 8'h14, 8'h1C, 8'h1F, 8'h24, 8'h5F};

   // Clock at 100 MHz
   always #5 clk = ~clk;

   dmm_data_memory dmm_data_memory_inst (
      .clk(clk), .resetn(resetn), .ce(ce), .rd_addr(rd_addr), .rd_data(rd_data),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_op(wr_op), .wr_bit(wr_bit), .wr_data(wr_data),
      .alu_wr_en(alu_wr_en), .alu_result(alu_result), .alu_result_reg(alu_result_reg),
      .lookup_load(lookup_load), .lookup_high_in(lookup_high_in),
      .flags_arith_load(flags_arith_load), .flags_arith_in(flags_arith_in),
      .timeout_flag_in(timeout_flag_in), .powerdown_flag_in(powerdown_flag_in),
      .pc_low_in(pc_low_in), .program_counter_low(program_counter_low),
      .pc_low_written(pc_low_written), .dummy_cycle(dummy_cycle));

   dmm_core_model dmm_core_model_inst (
      .clk(clk), .resetn(resetn), .program_counter_low(program_counter_low),
      .pc_low_written(pc_low_written), .dummy_cycle(dummy_cycle), .pc_low_in(pc_low_in),
      .timeout_flag_in(timeout_flag_in), .powerdown_flag_in(powerdown_flag_in));

   // Random source and expected bit operation result
   function automatic logic [7:0] lfsr_next();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic rnd(output logic [7:0] r);
      r = lfsr_next();
   endtask
   function automatic logic [7:0] bit_op(input logic [7:0] v, input logic [1:0] op, input logic [2:0] b);
      return (op == DMM_OP_SET) ? (v | (8'h01 << b)) : (v & ~(8'h01 << b));
   endfunction

   // Compare, write cycle, read cycle and closing report
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] op, input logic [2:0] b, input logic [7:0] d);
      @(negedge clk);
      wr_addr = a;
      wr_op = op;
      wr_bit = b;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd_addr = a;
      #1;
      check(rd_data, exp);
   endtask
   task automatic give_verdict();
      if (fails == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      logic [7:0] a, d, v, port, ptr;
      logic [1:0] op;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      rd(ADDR_POINTER_ZERO, ZERO_BYTE);
      wr(ADDR_GP_FIRST, DMM_OP_WRITE, 3'h0, 8'hA5);
      rd(ADDR_GP_FIRST, 8'hA5);
      wr(ADDR_GP_LAST, DMM_OP_WRITE, 3'h0, 8'h5A);
      rd(ADDR_GP_LAST, 8'h5A);
      ce = 1'b0;
      wr(ADDR_GP_FIRST, DMM_OP_WRITE, 3'h0, 8'h00);
      ce = 1'b1;
      rd(ADDR_GP_FIRST, 8'hA5);
      for (int i = 0; i < 16; i++) begin
         rnd(a);
         rnd(d);
         a = ADDR_GP_FIRST + a % 8'hA0;
         wr(a, DMM_OP_WRITE, 3'h0, d);
         rd(a, d);
      end
      foreach (rw_list[i]) begin
         rnd(d);
         wr(rw_list[i], DMM_OP_WRITE, 3'h0, d);
         rd(rw_list[i], d);
      end
      foreach (unused_list[i]) begin
         rnd(d);
         wr(unused_list[i], DMM_OP_WRITE, 3'h0, d | 8'h01);
         rd(unused_list[i], ZERO_BYTE);
      end
      wr(ADDR_LOOKUP_HIGH, DMM_OP_WRITE, 3'h0, 8'hFF);
      rd(ADDR_LOOKUP_HIGH, ZERO_BYTE);
      lookup_high_in = 8'h3C;
      lookup_load = 1'b1;
      @(negedge clk);
      lookup_load = 1'b0;
      rd(ADDR_LOOKUP_HIGH, 8'h3C);
      alu_result = 8'hC3;
      alu_wr_en = 1'b1;
      wr(ADDR_ALU_RESULT, DMM_OP_WRITE, 3'h0, 8'h11);
      alu_wr_en = 1'b0;
      check(alu_result_reg, 8'hC3);
      rd(ADDR_ALU_RESULT, 8'hC3);
      wr(ADDR_FLAGS, DMM_OP_WRITE, 3'h0, 8'hFF);
      rd(ADDR_FLAGS, 8'h2F);
      wr(ADDR_FLAGS, DMM_OP_SET, 3'h4, 8'h00);
      wr(ADDR_FLAGS, DMM_OP_CLR, 3'h5, 8'h00);
      wr(ADDR_FLAGS, DMM_OP_CLR, 3'h3, 8'h00);
      rd(ADDR_FLAGS, 8'h27);
      flags_arith_in = 4'h9;
      flags_arith_load = 1'b1;
      @(negedge clk);
      flags_arith_load = 1'b0;
      rd(ADDR_FLAGS, 8'h29);
      for (int i = 0; i < 2; i++) begin
         port = i ? ADDR_PORT_ONE : ADDR_PORT_ZERO;
         ptr = i ? ADDR_POINTER_ONE : ADDR_POINTER_ZERO;
         a = i ? 8'h71 : 8'h70;
         rnd(d);
         wr(a, DMM_OP_WRITE, 3'h0, d);
         wr(ptr, DMM_OP_WRITE, 3'h0, a);
         rd(ptr, a);
         rd(port, d);
         wr(port, DMM_OP_SET, 3'h7, 8'h00);
         wr(port, DMM_OP_CLR, 3'h0, 8'h00);
         rd(a, (d | 8'h80) & 8'hFE);
         rnd(d);
         wr(port, DMM_OP_WRITE, 3'h0, d);
         rd(a, d);
         wr(ptr, DMM_OP_WRITE, 3'h0, ADDR_LOOKUP_PTR);
         wr(port, DMM_OP_WRITE, 3'h0, 8'h5E);
         rd(ADDR_LOOKUP_PTR, 8'h5E);
         wr(ptr, DMM_OP_WRITE, 3'h0, port);
         wr(port, DMM_OP_WRITE, 3'h0, 8'hFF);
         rd(port, ZERO_BYTE);
         rd(ptr, port);
      end
      rnd(d);
      wr(ADDR_POINTER_ONE, DMM_OP_WRITE, 3'h0, d);
      wr(ADDR_POINTER_ZERO, DMM_OP_WRITE, 3'h0, ADDR_POINTER_ONE);
      rd(ADDR_PORT_ZERO, d);
      wr(ADDR_PORT_ZERO, DMM_OP_WRITE, 3'h0, ADDR_PORT_ZERO);
      rd(ADDR_POINTER_ONE, ADDR_PORT_ZERO);
      rd(ADDR_PORT_ONE, ZERO_BYTE);
      v = 8'h00;
      wr(ADDR_GP_FIRST, DMM_OP_WRITE, 3'h0, v);
      for (int i = 0; i < 12; i++) begin
         rnd(d);
         op = d[7] ? DMM_OP_SET : DMM_OP_CLR;
         wr(ADDR_GP_FIRST, op, d[2:0], ~d);
         v = bit_op(v, op, d[2:0]);
         rd(ADDR_GP_FIRST, v);
      end
      repeat (2) begin
         rnd(d);
         wr(ADDR_PC_LOW, DMM_OP_WRITE, 3'h0, d);
         check(program_counter_low, d);
         check({7'h00, pc_low_written}, 8'h01);
         @(negedge clk);
         check(program_counter_low, d);
         check({6'h00, pc_low_written, dummy_cycle}, 8'h01);
         @(negedge clk);
         check({6'h00, pc_low_written, dummy_cycle}, 8'h00);
         repeat (2) @(negedge clk);
         check(program_counter_low, d + 8'h01);
      end
      resetn = 1'b0;
      @(negedge clk);
      resetn = 1'b1;
      rd(ADDR_GP_FIRST, ZERO_BYTE);
      rd(ADDR_POINTER_ZERO, ZERO_BYTE);
      give_verdict();
   end
endmodule
